/* File: hdl/mai_audio_input.sv */
module mai_audio_input
	import mai_pkg::*;
(
	input  wire logic              ref_clk_in,
	input  wire logic              reset_in,
	input  wire logic              power_on_reset_n_in,
	input  wire logic              mclk_in,
	input  wire logic              bit_clk_in,
	output logic                   bit_clk_out,
	output logic                   bit_clk_oe_n_out,
	input  wire logic              word_clk_in,
	output logic                   word_clk_out,
	output logic                   word_clk_oe_n_out,
	input  wire logic [3:0]        channel_pair_data_inputs_in,
	input  wire logic              control_clock_pin_in,
	input  wire logic              control_data_pin_in,
	input  wire logic              control_latch_pin_in,
	output logic                   sample_valid_out,
	input  wire logic              sample_ready_in,
	output mai_sample_t            sample_out,
	output logic                   power_save_out,
	output logic [2:0]             ratio_out,
	output logic                   clock_role_select_out,
	output logic                   overrun_out
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int SW = 11;
	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;
	logic [SW-1:0] prev_q;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q  <= '0;
		end else begin
			sync1_q <= {power_on_reset_n_in, mclk_in, bit_clk_in, word_clk_in,
			            channel_pair_data_inputs_in, control_clock_pin_in,
			            control_data_pin_in, control_latch_pin_in};
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	logic       por_n_s;
	logic       mclk_s;
	logic       bclk_s;
	logic       wclk_s;
	logic [3:0] din_s;
	logic       cclk_s;
	logic       cdat_s;
	logic       clat_s;
	logic       rst;
	assign {por_n_s, mclk_s, bclk_s, wclk_s, din_s, cclk_s, cdat_s, clat_s} = sync2_q;
	assign rst = reset_in || !por_n_s;

	logic mclk_rise;
	assign mclk_rise = mclk_s && !prev_q[9];

	// ----------------------------------------------------------------
	// Control port
	// ----------------------------------------------------------------
	logic [MAI_CTL_W-1:0]  ctl_sh_q;
	logic                  ctl_commit;
	logic [MAI_ADDR_W-1:0] ctl_addr;
	logic [8:0]            ctl_data;

	// Pins pass the synchronisers before any use, so writes need no audio timing
	always_ff @(posedge ref_clk_in) begin
		if (rst) begin
			ctl_sh_q <= '0;
		end else if (cclk_s && !prev_q[2]) begin
			ctl_sh_q <= {ctl_sh_q[MAI_CTL_W-2:0], cdat_s};
		end
	end

	assign ctl_commit = !rst && clat_s && !prev_q[0];
	assign ctl_addr   = ctl_sh_q[MAI_ADDR_LSB +: MAI_ADDR_W];
	assign ctl_data   = ctl_sh_q[8:0];

	mai_iface_t iface_q;

	always_ff @(posedge ref_clk_in) begin
		if (rst) begin
			iface_q <= MAI_IFACE_RESET;
		end else if (ctl_commit && ctl_addr == MAI_ADDR_IFACE) begin
			iface_q.fmt    <= mai_fmt_t'(ctl_data[MAI_FMT_LSB +: 2]);
			iface_q.wl     <= mai_wl_t'(ctl_data[MAI_WL_LSB +: 2]);
			iface_q.master <= ctl_data[MAI_ROLE_BIT];
		end
	end
	assign clock_role_select_out = iface_q.master;

	// ----------------------------------------------------------------
	// Clock loss detection
	// ----------------------------------------------------------------
	logic [MAI_IDLE_W-1:0] idle_q;
	logic                  psave_q;

	// Counted on the reference clock so a dead master clock is still seen
	always_ff @(posedge ref_clk_in) begin
		if (rst || mclk_rise) begin
			idle_q <= '0;
		end else if (idle_q != MAI_IDLE_W'(MAI_LOSS_CYC)) begin
			idle_q <= idle_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst) begin
			psave_q <= 1'b0;
		end else if (mclk_rise) begin
			psave_q <= 1'b0;
		end else if (idle_q == MAI_IDLE_W'(MAI_LOSS_CYC - 1)) begin
			psave_q <= 1'b1;
		end
	end
	assign power_save_out = psave_q;

	logic audio_rst;
	assign audio_rst = rst || psave_q;

	psave_enter_a: assert property (@(posedge ref_clk_in) disable iff (rst)
		idle_q == MAI_IDLE_W'(MAI_LOSS_CYC - 1) && !mclk_rise |=> psave_q)
		else $error("clock loss not flagged");
	psave_exit_a: assert property (@(posedge ref_clk_in) disable iff (rst)
		psave_q && mclk_rise |=> !psave_q ##0 idle_q == '0)
		else $error("power save not left on clock restart");

	// ----------------------------------------------------------------
	// Ratio detection and master clock generation
	// ----------------------------------------------------------------
	function automatic logic [2:0] ratio_code(input logic [11:0] cnt);
		logic [2:0] code;
		code = MAI_RATIO_1152;
		for (int i = 0; i < MAI_NUM_RATIOS; i++) begin
			if ({1'b0, cnt} + 13'(MAI_RATIO_TOL) >= {2'b0, MAI_RATIO[i]} &&
			    {1'b0, cnt} <= {2'b0, MAI_RATIO[i]} + 13'(MAI_RATIO_TOL)) begin
				code = 3'(i);
			end
		end
		return code;
	endfunction : ratio_code

	logic [11:0] mcnt_q;
	logic [2:0]  ratio_q;
	logic        ratio_evt;
	assign ratio_evt = !iface_q.master && wclk_s && !prev_q[7];

	// Works at any frame rate, only the count per frame matters
	always_ff @(posedge ref_clk_in) begin
		if (audio_rst) begin
			mcnt_q  <= '0;
			ratio_q <= MAI_RATIO_RESET;
		end else if (ratio_evt) begin
			mcnt_q  <= {11'h000, mclk_rise};
			ratio_q <= ratio_code(mcnt_q);
		end else if (mclk_rise && mcnt_q != 12'hfff) begin
			mcnt_q <= mcnt_q + 1'b1;
		end
	end
	assign ratio_out = ratio_q;

	ratio_fallback_a: assert property (@(posedge ref_clk_in) disable iff (audio_rst)
		ratio_evt && (mcnt_q > 12'(MAI_RATIO[6]) + 12'(MAI_RATIO_TOL))
		|=> ratio_q == MAI_RATIO_1152)
		else $error("out of range ratio did not fall back");

	// Master: fixed 256fs, bit clock is master clock over four
	logic [1:0] mdiv_q;
	logic [4:0] mhalf_q;
	logic       bclk_m_q;
	logic       wclk_m_q;
	logic       m_tick;
	assign m_tick = mclk_rise && mdiv_q == 2'(MAI_MASTER_DIV - 1);

	always_ff @(posedge ref_clk_in) begin
		if (audio_rst || !iface_q.master) begin
			mdiv_q   <= '0;
			mhalf_q  <= '0;
			bclk_m_q <= 1'b0;
			wclk_m_q <= 1'b0;
		end else if (mclk_rise) begin
			mdiv_q <= m_tick ? 2'h0 : mdiv_q + 1'b1;
			if (m_tick) begin
				bclk_m_q <= !bclk_m_q;
				if (bclk_m_q) begin
					mhalf_q <= mhalf_q + 1'b1;
					if (mhalf_q == 5'(MAI_MASTER_HALF - 1)) begin
						wclk_m_q <= !wclk_m_q;
					end
				end
			end
		end
	end

	assign bit_clk_out       = bclk_m_q;
	assign word_clk_out      = wclk_m_q;
	assign bit_clk_oe_n_out  = !iface_q.master;
	assign word_clk_oe_n_out = !iface_q.master;

	role_pins_a: assert property (@(posedge ref_clk_in) disable iff (rst)
		bit_clk_oe_n_out == word_clk_oe_n_out && bit_clk_oe_n_out != iface_q.master)
		else $error("clock pin direction disagrees with role");
	word_edge_a: assert property (@(posedge ref_clk_in) disable iff (audio_rst)
		iface_q.master && $changed(wclk_m_q) |-> $fell(bclk_m_q))
		else $error("master word clock moved off falling bit clock");

	// ----------------------------------------------------------------
	// Serial receiver
	// ----------------------------------------------------------------
	function automatic logic [5:0] wl_bits(input mai_wl_t wl);
		case (wl)
			MAI_WL_16: return 6'd16;
			MAI_WL_20: return 6'd20;
			MAI_WL_24: return 6'd24;
			default:   return 6'd32;
		endcase
	endfunction : wl_bits

	function automatic logic [23:0] align(input logic [31:0] sh, input mai_wl_t wl);
		case (wl)
			MAI_WL_16: return {sh[15:0], 8'h00};
			MAI_WL_20: return {sh[19:0], 4'h0};
			MAI_WL_24: return sh[23:0];
			default:   return sh[31:8];
		endcase
	endfunction : align

	logic        bit_rise;
	logic        word_lvl;
	logic        word_prev_q;
	logic        frame_start;
	logic [6:0]  bitcnt_q;
	logic [6:0]  pos;
	logic [6:0]  off;
	logic [6:0]  wl7;
	logic [31:0] sh_q [4];
	logic        cap;
	logic        cap_right;
	logic        cap_old;

	assign bit_rise = iface_q.master ? (m_tick && !bclk_m_q) : (bclk_s && !prev_q[9 - 1]);
	assign word_lvl = iface_q.master ? wclk_m_q : wclk_s;
	assign frame_start = (iface_q.fmt == MAI_FMT_DSP) ? (word_lvl && !word_prev_q)
	                                                  : (word_lvl != word_prev_q);
	assign pos = frame_start ? 7'h00 : bitcnt_q;
	assign off = (iface_q.fmt == MAI_FMT_I2S || iface_q.fmt == MAI_FMT_DSP) ? 7'h01 : 7'h00;
	assign wl7 = {1'b0, wl_bits(iface_q.wl)};

	// Right-justified takes the word already shifted when the word clock turns
	always_comb begin
		cap       = 1'b0;
		cap_right = 1'b0;
		cap_old   = 1'b0;
		case (iface_q.fmt)
			MAI_FMT_RJ: begin
				cap       = frame_start;
				cap_right = !word_prev_q;
				cap_old   = 1'b1;
			end
			MAI_FMT_DSP: begin
				cap       = (pos == off + wl7 - 7'h01) || (pos == off + wl7 + wl7 - 7'h01);
				cap_right = (pos != off + wl7 - 7'h01);
			end
			MAI_FMT_I2S: begin
				cap       = (pos == off + wl7 - 7'h01);
				cap_right = word_lvl;
			end
			default: begin
				cap       = (pos == off + wl7 - 7'h01);
				cap_right = !word_lvl;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (audio_rst) begin
			word_prev_q <= 1'b0;
			bitcnt_q    <= '0;
		end else if (bit_rise) begin
			word_prev_q <= word_lvl;
			bitcnt_q    <= (pos == 7'h7f) ? pos : pos + 7'h01;
		end
	end

	// One shift register per stereo pair, common clocks for all four
	always_ff @(posedge ref_clk_in) begin
		if (audio_rst) begin
			for (int p = 0; p < 4; p++) sh_q[p] <= '0;
		end else if (bit_rise) begin
			for (int p = 0; p < 4; p++) sh_q[p] <= {sh_q[p][30:0], din_s[p]};
		end
	end

	// ----------------------------------------------------------------
	// Hand-off to the FIFO, volume and zero cross
	// ----------------------------------------------------------------
	logic [23:0]          hold_q [4];
	logic                 hold_right_q;
	logic [2:0]           emit_q;
	logic                 emit_fire;
	logic                 fifo_ready;
	logic [1:0]           emit_pair;
	logic [2:0]           emit_chan;
	logic [23:0]          emit_data;
	logic                 overrun_q;
	logic [MAI_VOL_W-1:0] pend_vol_q [8];
	logic [MAI_VOL_W-1:0] vol_q [8];
	logic [7:0]           upd_q;
	logic [7:0]           sign_q;
	logic                 zc;
	mai_sample_t          fifo_word;

	assign emit_pair = 2'(3'h4 - emit_q);
	assign emit_chan = {emit_pair, hold_right_q};
	assign emit_data = hold_q[emit_pair];
	assign emit_fire = emit_q != 3'h0 && fifo_ready;
	assign zc        = emit_data == 24'h000000 || emit_data[23] != sign_q[emit_chan];
	assign fifo_word = '{chan: emit_chan, vol: vol_q[emit_chan], data: emit_data};

	always_ff @(posedge ref_clk_in) begin
		if (audio_rst) begin
			emit_q       <= '0;
			hold_right_q <= 1'b0;
			for (int p = 0; p < 4; p++) hold_q[p] <= '0;
		end else if (bit_rise && cap && emit_q == 3'h0) begin
			emit_q       <= 3'h4;
			hold_right_q <= cap_right;
			for (int p = 0; p < 4; p++) begin
				hold_q[p] <= align(cap_old ? sh_q[p] : {sh_q[p][30:0], din_s[p]}, iface_q.wl);
			end
		end else if (emit_fire) begin
			emit_q <= emit_q - 1'b1;
		end
	end

	// A full FIFO stalls the hand-off; a frame that cannot be taken is lost
	always_ff @(posedge ref_clk_in) begin
		if (rst) begin
			overrun_q <= 1'b0;
		end else if (bit_rise && cap && emit_q != 3'h0) begin
			overrun_q <= 1'b1;
		end
	end
	assign overrun_out = overrun_q;

	// Stored settings survive power-save, only reset clears them
	always_ff @(posedge ref_clk_in) begin
		if (rst) begin
			for (int c = 0; c < 8; c++) pend_vol_q[c] <= MAI_VOL_RESET;
		end else if (ctl_commit && ctl_addr < 7'h08) begin
			pend_vol_q[ctl_addr[2:0]] <= ctl_data[MAI_VOL_W-1:0];
		end
	end

	// Power-save mutes the applied gain until software asks for an update
	always_ff @(posedge ref_clk_in) begin
		if (audio_rst) begin
			for (int c = 0; c < 8; c++) vol_q[c] <= rst ? MAI_VOL_RESET : MAI_VOL_MUTE;
			sign_q <= '0;
		end else if (emit_fire) begin
			sign_q[emit_chan] <= emit_data[23];
			if (upd_q[emit_chan] && zc) begin
				vol_q[emit_chan] <= pend_vol_q[emit_chan];
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst) begin
			upd_q <= '0;
		end else begin
			if (emit_fire && zc) begin
				upd_q[emit_chan] <= 1'b0;
			end
			// Update request beats a clear in the same cycle
			if (ctl_commit && ctl_addr < 7'h08 && ctl_data[MAI_UPDATE_BIT]) begin
				upd_q <= 8'hff;
			end
		end
	end

	zero_cross_a: assert property (@(posedge ref_clk_in) disable iff (audio_rst)
		emit_fire && emit_chan == 3'h4 && upd_q[4] && zc |=> vol_q[4] == $past(pend_vol_q[4]))
		else $error("volume not applied at zero cross");
	hold_gain_a: assert property (@(posedge ref_clk_in) disable iff (audio_rst)
		!upd_q[1] && !$past(upd_q[1]) |-> $stable(vol_q[1]))
		else $error("volume moved without update request");
	psave_write_a: assert property (@(posedge ref_clk_in) disable iff (rst)
		psave_q && ctl_commit && ctl_addr == 7'h00 |=> pend_vol_q[0] == $past(ctl_sh_q[7:0]))
		else $error("write lost during power save");
	por_default_a: assert property (@(posedge ref_clk_in)
		!reset_in && !por_n_s |=> pend_vol_q[0] == MAI_VOL_RESET && !iface_q.master)
		else $error("write accepted during power-on reset");

	mai_fifo #(
		.WIDTH(MAI_SAMPLE_W),
		.DEPTH(MAI_FIFO_DEPTH)
	) u_fifo (
		.ref_clk_in   (ref_clk_in),
		.reset_in     (audio_rst),
		.in_valid_in  (emit_q != 3'h0),
		.in_ready_out (fifo_ready),
		.in_data_in   (fifo_word),
		.out_valid_out(sample_valid_out),
		.out_ready_in (sample_ready_in),
		.out_data_out (sample_out)
	);

endmodule : mai_audio_input

/* File: hdl/mai_pkg.sv */
package mai_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int MAI_REF_PERIOD_NS  = 100;
	localparam int MAI_MCLK_MAX_NS    = 1000;
	localparam int MAI_LOSS_MIN_NS    = 2000;
	localparam int MAI_LOSS_MAX_NS    = 10000;
	// Least time rounds up
	localparam int MAI_LOSS_CYC       = (MAI_LOSS_MIN_NS + MAI_REF_PERIOD_NS - 1)
	                                    / MAI_REF_PERIOD_NS;
	localparam int MAI_IDLE_W         = 7;
	localparam int MAI_RATIO_TOL      = 32;
	localparam int MAI_MASTER_DIV     = 2;
	localparam int MAI_MASTER_HALF    = 32;

	// ----------------------------------------------------------------
	// Control word layout
	// ----------------------------------------------------------------
	localparam int MAI_CTL_W          = 16;
	localparam int MAI_ADDR_LSB       = 9;
	localparam int MAI_ADDR_W         = 7;
	localparam int MAI_VOL_W          = 8;
	localparam int MAI_UPDATE_BIT     = 8;
	localparam logic [6:0] MAI_ADDR_IFACE = 7'h08;
	localparam int MAI_FMT_LSB        = 0;
	localparam int MAI_WL_LSB         = 2;
	localparam int MAI_ROLE_BIT       = 4;
	localparam logic [7:0] MAI_VOL_RESET = 8'hff;
	localparam logic [7:0] MAI_VOL_MUTE  = 8'h00;

	// ----------------------------------------------------------------
	// Clock ratios
	// ----------------------------------------------------------------
	localparam int MAI_NUM_RATIOS     = 7;
	localparam logic [10:0] MAI_RATIO [0:6] = '{11'h080, 11'h0c0, 11'h100, 11'h180,
	                                             11'h200, 11'h300, 11'h480};
	localparam logic [2:0] MAI_RATIO_1152 = 3'h6;
	localparam logic [2:0] MAI_RATIO_RESET = 3'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MAI_FMT_RJ, MAI_FMT_LJ, MAI_FMT_I2S, MAI_FMT_DSP} mai_fmt_t;
	typedef enum logic [1:0] {MAI_WL_16, MAI_WL_20, MAI_WL_24, MAI_WL_32} mai_wl_t;

	typedef struct packed {
		mai_fmt_t fmt;
		mai_wl_t  wl;
		logic     master;
	} mai_iface_t;

	localparam mai_iface_t MAI_IFACE_RESET = '{fmt: MAI_FMT_I2S, wl: MAI_WL_24, master: 1'b0};

	typedef struct packed {
		logic [2:0]  chan;
		logic [7:0]  vol;
		logic [23:0] data;
	} mai_sample_t;

	localparam int MAI_SAMPLE_W = $bits(mai_sample_t);
	localparam int MAI_FIFO_DEPTH = 32;

endpackage : mai_pkg

/* File: hdl/mai_fifo.sv */
module mai_fifo #(
	parameter int WIDTH = 35,
	parameter int DEPTH = 32
) (
	input  wire logic             ref_clk_in,
	input  wire logic             reset_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	logic             full;
	logic             empty;

	assign empty         = (wr_q == rd_q);
	assign full          = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign in_ready_out  = !full;
	assign out_valid_out = !empty;
	assign out_data_out  = mem_q[rd_q[AW-1:0]];

	always_ff @(posedge ref_clk_in) begin
		if (in_valid_in && !full) begin
			mem_q[wr_q[AW-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			wr_q <= '0;
		end else if (in_valid_in && !full) begin
			wr_q <= wr_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			rd_q <= '0;
		end else if (out_ready_in && !empty) begin
			rd_q <= rd_q + 1'b1;
		end
	end

	fifo_hold_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out))
		else $error("fifo head changed while stalled");

endmodule : mai_fifo

/* File: tb/mai_src_model.sv */
module mai_src_model (
	input  wire logic       ref_clk_in,
	input  wire logic       run_in,
	input  wire logic       mclk_run_in,
	output logic            mclk_out,
	output logic            bit_clk_out,
	output logic            word_clk_out,
	output logic [3:0]      data_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [2:0] ph_q;
	logic [5:0] bit_q;
	logic       mc_q;

	function automatic logic [23:0] smp(input logic [2:0] ch);
		return {ch, 21'h15a5a5};
	endfunction : smp

	// I2S, 24-bit words in 32-bit halves, MSB one bit after the word edge
	function automatic logic lvl(input logic [1:0] p, input logic [5:0] b);
		logic [23:0] s;
		s = smp({p, b[5]});
		return (b[4:0] >= 5'h01 && b[4:0] <= 5'h18) ? s[5'h18 - b[4:0]] : 1'b0;
	endfunction : lvl

	initial begin
		{ph_q, bit_q, mc_q, mclk_out, bit_clk_out, word_clk_out, data_out} = '0;
	end

	// ----------------------------------------------------------------
	// Master clock, 128 per frame
	// ----------------------------------------------------------------
	always @(posedge ref_clk_in) begin
		mc_q <= ~mc_q;
		if (mclk_run_in && mc_q)
			mclk_out <= ~mclk_out;
	end

	// ----------------------------------------------------------------
	// Frames
	// ----------------------------------------------------------------
	always @(posedge ref_clk_in) begin
		if (!run_in) begin
			// Clock stands still, released lines keep moving
			bit_clk_out <= 1'b0;
			data_out    <= ~data_out;
			ph_q        <= 3'h0;
			bit_q       <= 6'h00;
		end else begin
			ph_q        <= ph_q + 3'h1;
			bit_clk_out <= ph_q[2];
			if (ph_q == 3'h0) begin
				bit_q        <= bit_q + 6'h01;
				word_clk_out <= bit_q[5];
				for (int p = 0; p < 4; p++)
					data_out[p] <= lvl(p[1:0], bit_q);
			end
		end
	end
endmodule : mai_src_model

/* File: tb/multichannel_audio_input_port_tb.sv */
module multichannel_audio_input_port_tb
	import mai_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk, rst, por_n, run, mrun, ready, cc, cd, cl;
	logic        mck, mbck, mwck, bck_o, bck_oe_n, wck_o, wck_oe_n;
	logic        vld, psave, role, ovr;
	logic [3:0]  din;
	logic [2:0]  ratio;
	mai_sample_t smp_o;
	wire logic   bck_w = bck_oe_n ? mbck : bck_o;
	wire logic   wck_w = wck_oe_n ? mwck : wck_o;
	int          errors, cmp_count;

	always #50 clk = ~clk;

	mai_src_model i_mai_src_model (.ref_clk_in(clk), .run_in(run), .mclk_run_in(mrun),
		.mclk_out(mck), .bit_clk_out(mbck), .word_clk_out(mwck), .data_out(din));

	mai_audio_input i_mai_audio_input (.ref_clk_in(clk), .reset_in(rst),
		.power_on_reset_n_in(por_n), .mclk_in(mck), .bit_clk_in(bck_w),
		.bit_clk_out(bck_o), .bit_clk_oe_n_out(bck_oe_n), .word_clk_in(wck_w),
		.word_clk_out(wck_o), .word_clk_oe_n_out(wck_oe_n),
		.channel_pair_data_inputs_in(din), .control_clock_pin_in(cc),
		.control_data_pin_in(cd), .control_latch_pin_in(cl), .sample_valid_out(vld),
		.sample_ready_in(ready), .sample_out(smp_o), .power_save_out(psave),
		.ratio_out(ratio), .clock_role_select_out(role), .overrun_out(ovr));

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic chk(input logic [34:0] got, input logic [34:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Each pin level held three cycles so the synchronisers see it
	task automatic wr(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			cd <= w[i];
			tick(3);
			cc <= 1'b1;
			tick(3);
			cc <= 1'b0;
		end
		tick(3);
		cl <= 1'b1;
		tick(3);
		cl <= 1'b0;
		tick(5);
	endtask : wr

	task automatic test_reset;
		chk({psave, vld, ratio, role, bck_oe_n, wck_oe_n, ovr}, 9'h026, "rst");
		$display("test reset done");
	endtask : test_reset

	// Fill the buffer with the consumer stalled, then drain it
	task automatic test_stream;
		int n;
		ready <= 1'b0;
		run   <= 1'b1;
		tick(3000);
		chk({vld, ovr}, 2'h3, "full");
		chk(ratio, 3'h0, "ratio");
		n = 0;
		ready <= 1'b1;
		for (int k = 0; k < 300; k++) begin
			@(posedge clk);
			#1;
			if (vld === 1'b1) begin
				chk(smp_o.data, i_mai_src_model.smp(smp_o.chan), "data");
				n++;
			end
		end
		chk(n >= 32, 1'b1, "drained");
		tick(1);
		run <= 1'b0;
		tick(900);
		chk(vld, 1'b0, "empty");
		$display("test stream done");
	endtask : test_stream

	task automatic test_loss;
		int k;
		mrun <= 1'b0;
		tick(15);
		chk(psave, 1'b0, "early save");
		for (k = 0; k < 90 && psave !== 1'b1; k++)
			tick(1);
		chk(psave, 1'b1, "save");
		wr(16'h101a);
		chk({role, bck_oe_n, wck_oe_n}, 3'h4, "master");
		wr(16'h0080);
		por_n <= 1'b0;
		tick(5);
		wr(16'h101a);
		por_n <= 1'b1;
		tick(5);
		chk({role, ratio}, 4'h2, "por");
		// Reset cleared power-save, so let it come back before the restart
		tick(25);
		chk(psave, 1'b1, "save again");
		mrun <= 1'b1;
		for (k = 0; k < 10 && psave !== 1'b0; k++)
			tick(1);
		chk(psave, 1'b0, "resume");
		wr(16'h01ff);
		$display("test loss done");
	endtask : test_loss

	// Long idle frame clock forces the fallback ratio; only a signal that crossed zero regains gain
	task automatic test_volume;
		int n;
		ready <= 1'b1;
		tick(4800);
		run <= 1'b1;
		tick(600);
		chk(ratio, MAI_RATIO_1152, "fallback");
		chk(ovr, 1'b0, "ovr");
		n = 0;
		for (int k = 0; k < 300; k++) begin
			@(posedge clk);
			#1;
			if (vld === 1'b1) begin
				chk(smp_o.vol, smp_o.chan[2] ? MAI_VOL_RESET : MAI_VOL_MUTE, "vol");
				n++;
			end
		end
		chk(n, 4, "frame");
		tick(1);
		$display("test volume done");
	endtask : test_volume

	// Master clocks: bit clock is master clock over four, 64 bit clocks a frame
	task automatic test_master;
		int   nb;
		int   nw;
		logic pb;
		logic pw;
		wr(16'h101a);
		chk({role, bck_oe_n, wck_oe_n}, 3'h4, "oe");
		nb = 0;
		nw = 0;
		pb = bck_o;
		pw = wck_o;
		for (int k = 0; k < 1024; k++) begin
			tick(1);
			if (bck_o && !pb)
				nb++;
			if (wck_o != pw)
				nw++;
			pb = bck_o;
			pw = wck_o;
		end
		chk(nb, 64, "bit clocks");
		chk(nw, 2, "word edges");
		$display("test master done");
	endtask : test_master

	task automatic summarize;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	initial begin
		#2000000;
		errors++;
		summarize();
	end

	initial begin
		{clk, por_n, run, mrun, ready, cc, cd, cl} = 8'h50;
		rst = 1'b1;
		errors = 0;
		cmp_count = 0;
		tick(8);
		rst <= 1'b0;
		tick(4);
		test_reset();
		test_stream();
		test_loss();
		test_volume();
		test_master();
		summarize();
	end
endmodule : multichannel_audio_input_port_tb
